// >>> src/tpx_target.sv
module tpx_target #(
	parameter logic [6:0] TARGET_ADDR = tpx_pkg::TARGET_ADDR_DEF,
	parameter int unsigned TIMEOUT_CYCLES = tpx_pkg::TMO_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [tpx_pkg::NUM_PORTS-1:0] port_i,
	output logic [tpx_pkg::NUM_PORTS-1:0] port_o,
	output logic [tpx_pkg::NUM_PORTS-1:0] port_oe
);
	localparam int unsigned NP = tpx_pkg::NUM_PORTS;
	localparam logic [tpx_pkg::TMO_W-1:0] TMO_LIMIT = tpx_pkg::TMO_W'(TIMEOUT_CYCLES);

	generate
		if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << tpx_pkg::TMO_W)) begin : g_bad_tmo
			$error("TIMEOUT_CYCLES out of counter range");
		end
		if (NP != 4) begin : g_bad_np
			$error("port count must be four");
		end
	endgenerate

	// Pin synchronisers and line history
	logic scl_m_reg, scl_s_reg, scl_q_reg;
	logic sda_m_reg, sda_s_reg, sda_q_reg;
	logic [NP-1:0] pin_m_reg, pin_s_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{scl_m_reg, scl_s_reg, scl_q_reg} <= 3'h7;
			{sda_m_reg, sda_s_reg, sda_q_reg} <= 3'h7;
			pin_m_reg <= '0;
			pin_s_reg <= '0;
		end else begin
			{scl_m_reg, scl_s_reg, scl_q_reg} <= {scl_i, scl_m_reg, scl_s_reg};
			{sda_m_reg, sda_s_reg, sda_q_reg} <= {sda_i, sda_m_reg, sda_s_reg};
			pin_m_reg <= port_i;
			pin_s_reg <= pin_m_reg;
		end
	end

	wire scl_rise = scl_s_reg && !scl_q_reg;
	wire scl_fall = !scl_s_reg && scl_q_reg;
	wire start_det = scl_s_reg && scl_q_reg && sda_q_reg && !sda_s_reg;
	wire stop_det = scl_s_reg && scl_q_reg && !sda_q_reg && sda_s_reg;
	wire line_evt = (scl_s_reg ^ scl_q_reg) || (sda_s_reg ^ sda_q_reg);
	wire line_low = !scl_s_reg || !sda_s_reg;

	// Protocol state
	tpx_pkg::tpx_state_e state_reg, state_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] fetch_ptr_reg;
	logic got_addr_reg, got_addr_next;
	logic got_cmd_reg, got_cmd_next;
	logic rd_mode_reg, rd_mode_next;
	logic nack_reg, nack_next;
	logic sda_oe_reg, sda_oe_next;
	logic sda_o_reg;
	logic [7:0] cfg_reg;
	logic [tpx_pkg::TMO_W-1:0] tmo_cnt_reg, tmo_cnt_next;
	logic [NP-1:0] port_o_reg, port_oe_reg;
	logic reg_we, pop, flush, load_tx;

	// Timeout
	wire tmo_en = !cfg_reg[tpx_pkg::CFG_TMO_OFF_BIT];
	wire busy = state_reg != tpx_pkg::ST_IDLE;
	wire tmo_hit = tmo_en && (tmo_cnt_reg == TMO_LIMIT);
	wire tmo_clear = tmo_hit || !tmo_en || !busy || line_evt || start_det || stop_det || !line_low;

	assign tmo_cnt_next = tmo_clear ? '0 : tmo_cnt_reg + tpx_pkg::TMO_W'(1);

	// Read-ahead buffer between register file and shifter
	logic buf_in_ready, buf_out_valid;
	logic [7:0] buf_out_data;
	wire push_valid = rd_mode_reg && busy && state_reg != tpx_pkg::ST_RX && !flush;
	wire rd_is_cfg = fetch_ptr_reg == tpx_pkg::CFG_ADDR;
	wire rd_is_port = fetch_ptr_reg >= tpx_pkg::PORT_BASE && fetch_ptr_reg < tpx_pkg::PORT_BASE + 8'(NP);
	wire [1:0] rd_port_idx = 2'(fetch_ptr_reg - tpx_pkg::PORT_BASE);
	wire [7:0] port_view [NP];
	wire [7:0] rd_data = rd_is_cfg ? cfg_reg : rd_is_port ? port_view[rd_port_idx] : tpx_pkg::UNMAPPED_READ;
	wire addr_hit = shift_reg[7:1] == TARGET_ADDR;
	wire rd_dir = shift_reg[0];

	tpx_buf #(
		.WIDTH(tpx_pkg::BYTE_W),
		.DEPTH(tpx_pkg::BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rstn(rstn),
		.flush(flush),
		.in_valid(push_valid),
		.in_ready(buf_in_ready),
		.in_data(rd_data),
		.out_valid(buf_out_valid),
		.out_ready(pop),
		.out_data(buf_out_data)
	);

	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		got_addr_next = got_addr_reg;
		got_cmd_next = got_cmd_reg;
		rd_mode_next = rd_mode_reg;
		nack_next = nack_reg;
		sda_oe_next = sda_oe_reg;
		reg_we = 1'b0;
		flush = 1'b0;
		load_tx = 1'b0;
		if (tmo_hit) begin
			state_next = tpx_pkg::ST_IDLE;
			sda_oe_next = 1'b0;
		end else if (start_det) begin
			state_next = tpx_pkg::ST_RX;
			bit_cnt_next = 4'h0;
			got_addr_next = 1'b0;
			got_cmd_next = 1'b0;
			rd_mode_next = 1'b0;
			sda_oe_next = 1'b0;
		end else if (stop_det) begin
			state_next = tpx_pkg::ST_IDLE;
			sda_oe_next = 1'b0;
		end else begin
			unique case (state_reg)
				tpx_pkg::ST_IDLE: begin
				end
				tpx_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s_reg};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == tpx_pkg::BITS_PER_BYTE) begin
						if (!got_addr_reg) begin
							if (addr_hit) begin
								got_addr_next = 1'b1;
								rd_mode_next = rd_dir;
								flush = rd_dir;
								state_next = tpx_pkg::ST_RX_ACK;
								sda_oe_next = 1'b1;
							end else begin
								state_next = tpx_pkg::ST_IDLE;
							end
						end else if (!got_cmd_reg) begin
							got_cmd_next = 1'b1;
							ptr_next = shift_reg;
							state_next = tpx_pkg::ST_RX_ACK;
							sda_oe_next = 1'b1;
						end else begin
							reg_we = 1'b1;
							ptr_next = ptr_reg + 8'h01;
							state_next = tpx_pkg::ST_RX_ACK;
							sda_oe_next = 1'b1;
						end
					end
				end
				tpx_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						sda_oe_next = 1'b0;
						if (rd_mode_reg) begin
							load_tx = 1'b1;
						end else begin
							state_next = tpx_pkg::ST_RX;
						end
					end
				end
				tpx_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == tpx_pkg::LAST_TX_BIT) begin
							state_next = tpx_pkg::ST_TX_ACK;
							sda_oe_next = 1'b0;
						end else begin
							tx_next = {tx_reg[6:0], 1'b1};
							sda_oe_next = !tx_reg[6];
							bit_cnt_next = bit_cnt_reg + 4'h1;
						end
					end
				end
				tpx_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						nack_next = sda_s_reg;
					end else if (scl_fall) begin
						if (nack_reg) begin
							state_next = tpx_pkg::ST_IDLE;
						end else begin
							load_tx = 1'b1;
						end
					end
				end
				default: begin
					state_next = tpx_pkg::ST_IDLE;
					sda_oe_next = 1'b0;
				end
			endcase
		end
		if (load_tx) begin
			tx_next = buf_out_valid ? buf_out_data : tpx_pkg::EMPTY_READ;
			sda_oe_next = !tx_next[7];
			ptr_next = ptr_reg + 8'h01;
			bit_cnt_next = 4'h0;
			state_next = tpx_pkg::ST_TX;
		end
	end

	assign pop = load_tx && buf_out_valid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= tpx_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'hFF;
			ptr_reg <= tpx_pkg::PTR_RESET;
			{got_addr_reg, got_cmd_reg, rd_mode_reg, nack_reg} <= 4'h0;
			sda_oe_reg <= 1'b0;
			sda_o_reg <= 1'b0;
			tmo_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			{got_addr_reg, got_cmd_reg, rd_mode_reg, nack_reg} <= {got_addr_next, got_cmd_next, rd_mode_next, nack_next};
			sda_oe_reg <= sda_oe_next;
			sda_o_reg <= 1'b0;
			tmo_cnt_reg <= tmo_cnt_next;
		end
	end

	// Read-ahead pointer follows the stored pointer at each read address
	wire fetch_adv = push_valid && buf_in_ready;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fetch_ptr_reg <= tpx_pkg::PTR_RESET;
		end else if (flush) begin
			fetch_ptr_reg <= ptr_reg;
		end else if (fetch_adv) begin
			fetch_ptr_reg <= fetch_ptr_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= tpx_pkg::CFG_RESET;
		end else if (reg_we && ptr_reg == tpx_pkg::CFG_ADDR) begin
			cfg_reg <= shift_reg;
		end
	end

	// One register per port, so a write touches a single port
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_port
			wire port_sel = reg_we && ptr_reg == tpx_pkg::PORT_BASE + 8'(gi);
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					port_o_reg[gi] <= 1'b0;
					port_oe_reg[gi] <= 1'b0;
				end else if (port_sel) begin
					port_o_reg[gi] <= shift_reg[tpx_pkg::PORT_LEVEL_BIT];
					port_oe_reg[gi] <= shift_reg[tpx_pkg::PORT_DRIVE_BIT];
				end
			end
			assign port_view[gi] = {pin_s_reg[gi], 5'h00, port_oe_reg[gi], port_o_reg[gi]};
		end
	endgenerate

	assign sda_o = sda_o_reg;
	assign sda_oe = sda_oe_reg;
	assign port_o = port_o_reg;
	assign port_oe = port_oe_reg;

	a_idle_release: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == tpx_pkg::ST_IDLE |-> !sda_oe_reg)
		else $error("data line driven while idle");

	a_idle_wake_start: assert property (@(posedge clk) disable iff (!rstn)
		(state_reg == tpx_pkg::ST_IDLE ##1 state_reg != tpx_pkg::ST_IDLE) |-> $past(start_det))
		else $error("left idle without a START");

	a_timeout_reset: assert property (@(posedge clk) disable iff (!rstn)
		tmo_hit |=> state_reg == tpx_pkg::ST_IDLE && !sda_oe_reg && tmo_cnt_reg == '0)
		else $error("timeout did not reset interface");

	a_tmo_disabled: assert property (@(posedge clk) disable iff (!rstn)
		cfg_reg[tpx_pkg::CFG_TMO_OFF_BIT] |=> tmo_cnt_reg == '0)
		else $error("timeout counted while disabled");

	a_tmo_clears_edge: assert property (@(posedge clk) disable iff (!rstn)
		(busy && line_evt) |=> tmo_cnt_reg == '0)
		else $error("timeout counter kept running over a line edge");

	a_tmo_stuck_low: assert property (@(posedge clk) disable iff (!rstn)
		(tmo_cnt_reg == TMO_LIMIT - tpx_pkg::TMO_W'(1) && tmo_en && !tmo_clear) |=> ##1 state_reg == tpx_pkg::ST_IDLE)
		else $error("stuck line not timed out");

	a_ptr_advance: assert property (@(posedge clk) disable iff (!rstn)
		load_tx |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
		else $error("pointer not advanced after a read byte");

	a_read_first: assert property (@(posedge clk) disable iff (!rstn)
		flush |=> fetch_ptr_reg == $past(ptr_reg))
		else $error("read does not start at the stored pointer");

	a_cmd_only: assert property (@(posedge clk) disable iff (!rstn)
		(got_addr_reg && !got_cmd_reg) |-> !reg_we)
		else $error("command byte wrote a register");

	a_addr_match: assert property (@(posedge clk) disable iff (!rstn)
		$rose(got_addr_reg) |-> shift_reg[7:1] == TARGET_ADDR && sda_oe_reg)
		else $error("acknowledged a foreign address");

	a_one_port: assert property (@(posedge clk) disable iff (!rstn)
		$onehot0((port_o_reg ^ $past(port_o_reg)) | (port_oe_reg ^ $past(port_oe_reg))))
		else $error("several ports changed in one write");

	c_read_byte: cover property (@(posedge clk) disable iff (!rstn) pop && rd_is_cfg);
	c_timeout: cover property (@(posedge clk) disable iff (!rstn) tmo_hit);
	c_port_write: cover property (@(posedge clk) disable iff (!rstn) reg_we && ptr_reg == tpx_pkg::PORT_BASE);
	c_buf_full: cover property (@(posedge clk) disable iff (!rstn) rd_mode_reg && !buf_in_ready);

endmodule

// >>> src/tpx_pkg.sv
package tpx_pkg;

	// Register map
	localparam logic [7:0] CFG_ADDR = 8'h27;
	localparam int unsigned CFG_TMO_OFF_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] PORT_BASE = 8'h20;
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned PORT_LEVEL_BIT = 0;
	localparam int unsigned PORT_DRIVE_BIT = 1;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] EMPTY_READ = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Bus target address and byte framing
	localparam logic [6:0] TARGET_ADDR_DEF = 7'h4C;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	// Bus timeout
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TMO_MS = 31;
	localparam int unsigned TMO_CYCLES = TMO_MS * (CLK_HZ / 1000);
	localparam int unsigned TMO_W = 22;

	// Read-ahead buffer
	localparam int unsigned BUF_DEPTH = 2;
	localparam int unsigned BYTE_W = 8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_RX_ACK = 3'h2,
		ST_TX = 3'h3,
		ST_TX_ACK = 3'h4
	} tpx_state_e;

endpackage

// >>> src/tpx_buf.sv
module tpx_buf #(
	parameter int unsigned WIDTH = tpx_pkg::BYTE_W,
	parameter int unsigned DEPTH = tpx_pkg::BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("tpx_buf depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_idx_reg;
	logic [AW-1:0] rd_idx_reg;
	logic [AW:0] cnt_reg;

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = cnt_reg != (AW + 1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rd_idx_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_idx_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_idx_reg <= '0;
			rd_idx_reg <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			wr_idx_reg <= '0;
			rd_idx_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_idx_reg <= wr_idx_reg + AW'(push);
			rd_idx_reg <= rd_idx_reg + AW'(pop);
			cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	a_buf_no_overflow: assert property (@(posedge clk) disable iff (!rstn)
		cnt_reg <= (AW + 1)'(DEPTH))
		else $error("buffer count above depth");

endmodule

// >>> verification/tpx_master.sv
module tpx_master (
	input wire logic clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda_drv,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clocks per bus phase; raised to act as a slow master
	int half = 10;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Also a repeated START when entered with the clock low
	task automatic start();
		sda_drv = 1'b1;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_drv = 1'b0;
		tick(half);
		scl = 1'b0;
		tick(half);
	endtask

	task automatic stop();
		sda_drv = 1'b0;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_drv = 1'b1;
		tick(half);
	endtask

	// Data changes only while the clock is low
	task automatic bitx(input logic b, output logic s);
		sda_drv = b;
		tick(half);
		scl = 1'b1;
		tick(half);
		s = sda_in;
		scl = 1'b0;
		tick(2);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], ack);
		end
		bitx(1'b1, ack);
	endtask

	task automatic rbyte(input logic nack);
		logic s;
		logic [7:0] v;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			v[i] = s;
		end
		rx_byte = v;
		rx_stb = 1'b1;
		tick(1);
		rx_stb = 1'b0;
		bitx(nack, s);
	endtask
endmodule

// >>> verification/tpx_target_tb_top.sv
module tpx_target_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [6:0] ADDR = tpx_pkg::TARGET_ADDR_DEF;
	localparam int unsigned TMO = 200;

	logic clk, rstn, scl, m_sda, sda_o, sda_oe, sda_w, rx_stb, a;
	logic [3:0] port_i, port_o, port_oe, eo, eoe;
	logic [7:0] rx_byte, seed, d, cfg, pm;
	logic [7:0] exp_q[$];
	int n_fail, tests_run;

	// Open-drain data line with pull-up
	assign sda_w = m_sda & ~(sda_oe & ~sda_o);

	tpx_target #(.TIMEOUT_CYCLES(TMO)) i_tpx_target (.clk(clk), .rstn(rstn), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .port_i(port_i), .port_o(port_o), .port_oe(port_oe));

	tpx_master i_tpx_master (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_drv(m_sda), .rx_byte(rx_byte),
		.rx_stb(rx_stb));

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [7:0] regv(input logic [7:0] r);
		logic [7:0] k;
		k = r - tpx_pkg::PORT_BASE;
		if (k < 8'h04) return {port_i[k[1:0]], 5'h00, eoe[k[1:0]], eo[k[1:0]]};
		if (r == tpx_pkg::CFG_ADDR) return cfg;
		return tpx_pkg::UNMAPPED_READ;
	endfunction

	task automatic ports();
		chk("port_o", {4'h0, port_o}, {4'h0, eo});
		chk("port_oe", {4'h0, port_oe}, {4'h0, eoe});
	endtask

	// Pointer write then n data bytes; m forces the data when nonzero
	task automatic wr(input logic [7:0] ptr, input int n, input logic [7:0] m);
		logic [7:0] r;
		i_tpx_master.start();
		i_tpx_master.wbyte({ADDR, 1'b0}, a);
		chk("ack", {7'h00, a}, 8'h00);
		i_tpx_master.wbyte(ptr, a);
		chk("ack", {7'h00, a}, 8'h00);
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			d = (m == 8'h00) ? seed : m;
			r = ptr + i[7:0];
			i_tpx_master.wbyte(d, a);
			if (r == tpx_pkg::CFG_ADDR) cfg = d;
			else if (r - tpx_pkg::PORT_BASE < 8'h04) begin
				eo[r[1:0]] = d[0];
				eoe[r[1:0]] = d[1];
			end
			ports();
		end
		i_tpx_master.stop();
		ports();
		pm = ptr + n[7:0];
	endtask

	task automatic rd(input logic [7:0] ptr, input int n, input bit set);
		// New pin levels well before the read-ahead fetch samples them
		seed = lfsr(seed);
		port_i = seed[3:0];
		if (set) begin
			i_tpx_master.start();
			i_tpx_master.wbyte({ADDR, 1'b0}, a);
			i_tpx_master.wbyte(ptr, a);
			chk("ack", {7'h00, a}, 8'h00);
			pm = ptr;
		end
		i_tpx_master.start();
		i_tpx_master.wbyte({ADDR, 1'b1}, a);
		chk("ack", {7'h00, a}, 8'h00);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(regv(pm));
			pm++;
			i_tpx_master.rbyte(i == n - 1);
		end
		i_tpx_master.stop();
	endtask

	// Start a read of port 0 (msb low, so data is pulled) and hold the clock low
	task automatic stall(input logic [7:0] want);
		port_i[0] = 1'b0;
		wr(8'h20, 0, 8'h00);
		i_tpx_master.start();
		i_tpx_master.wbyte({ADDR, 1'b1}, a);
		i_tpx_master.tick(8);
		chk("sda_oe", {7'h00, sda_oe}, 8'h01);
		i_tpx_master.tick(TMO + 50);
		chk("sda_oe", {7'h00, sda_oe}, want);
	endtask

	always @(posedge clk) if (rx_stb === 1'b1) chk("rdata", rx_byte, exp_q.pop_front());

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#500_000;
		n_fail++;
		summarize();
	end

	initial begin
		rstn = 1'b0;
		port_i = 4'b1010;
		seed = 8'h49;
		{eo, eoe, cfg, pm, n_fail, tests_run} = '0;
		i_tpx_master.tick(5);
		ports();
		chk("sda_oe", {7'h00, sda_oe}, 8'h00);
		rstn = 1'b1;
		i_tpx_master.tick(3);
		rd(8'h27, 1, 1'b1);
		wr(8'h20, 4, 8'h00);
		rd(8'h20, 4, 1'b1);
		i_tpx_master.half = 20;
		rd(pm, 3, 1'b0);
		i_tpx_master.half = 10;
		wr(8'h22, 0, 8'h00);
		rd(pm, 2, 1'b0);
		i_tpx_master.start();
		i_tpx_master.wbyte({ADDR ^ 7'h01, 1'b0}, a);
		chk("ack", {7'h00, a}, 8'h01);
		i_tpx_master.stop();
		stall(8'h00);
		i_tpx_master.wbyte({ADDR, 1'b0}, a);
		chk("ack", {7'h00, a}, 8'h01);
		i_tpx_master.stop();
		wr(8'h27, 1, 8'h80);
		rd(8'h27, 1, 1'b1);
		stall(8'h01);
		exp_q.push_back(regv(8'h20));
		i_tpx_master.rbyte(1'b1);
		i_tpx_master.stop();
		rstn = 1'b0;
		i_tpx_master.tick(2);
		{eo, eoe, cfg} = '0;
		ports();
		rstn = 1'b1;
		i_tpx_master.tick(3);
		rd(8'h20, 1, 1'b1);
		rd(8'h27, 1, 1'b1);
		i_tpx_master.tick(20);
		summarize();
	end
endmodule
